// ===== core/kpi_pkg.sv
// package: register map, field positions and carrier types for the keypad interrupt unit
package kpi_pkg;
    localparam int unsigned KPI_ADDR_W      = 4;
    localparam int unsigned KPI_DATA_W      = 32;
    localparam int unsigned KPI_PINS        = 8;
    // byte offsets on the bus
    localparam logic [3:0]  KPI_OFF_STSCTL  = 4'h0;
    localparam logic [3:0]  KPI_OFF_PINEN   = 4'h4;
    localparam logic [3:0]  KPI_OFF_STOP    = 4'h8;
    // status/control field positions
    localparam int unsigned KPI_POL_LSB     = 4;
    localparam int unsigned KPI_FLAG_BIT    = 3;
    localparam int unsigned KPI_ACK_BIT     = 2;
    localparam int unsigned KPI_IE_BIT      = 1;
    localparam int unsigned KPI_MODE_BIT    = 0;
    // reset values
    localparam logic [3:0]  KPI_POL_RST     = 4'h0;
    localparam logic [7:0]  KPI_PINEN_RST   = 8'h00;
    localparam logic [31:0] KPI_UNMAPPED    = 32'h0000_0000;

    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [KPI_ADDR_W-1:0] address;
        logic [KPI_DATA_W-1:0] writedata;
    } kpi_bus_req_t;

    typedef struct packed {
        logic                  waitrequest;
        logic                  readdatavalid;
        logic [KPI_DATA_W-1:0] readdata;
    } kpi_bus_rsp_t;

    typedef enum logic [1:0] {
        KPI_BUS_IDLE = 2'b00,
        KPI_BUS_DONE = 2'b01
    } kpi_bus_state_t;
endpackage

// ===== core/kpi_keypad_interrupt_unit.sv
// keypad interrupt unit: pin sync, edge/level detect, flag, avalon-mm registers
`timescale 1ns/1ns

// Contract
// (RL1) upper pins: polarity bit picks trigger sense
// (RL2) edge on enabled pin sets read-only flag
// (RL3) writing one to ack clears flag
// (RL4) level mode: asserted pin keeps flag set
// (RL5) ack bit always reads back zero
// (RL6) irq enable forwards flag to cpu
// (RL7) mode bit: edge-only or edge-and-level
// (RL8) lower pins sense only falling/low
// (RL9) pin enable connects pin, else ignored
// (RL10) software clears flag before stop mode
// (RL11) edge is one sample then opposite next
// (RL12) edge counts only from deasserted state
// (RL13) stop mode: async level wakeup sources; the code takes them through the synchroniser and a flop on mclk_in
// (RL14) reset clears all controls and flag
// (RL15) irq equals flag and enable, level
module kpi_keypad_interrupt_unit #(
    parameter int unsigned PINS = kpi_pkg::KPI_PINS
) (
    // clock and reset
    input  wire logic                      mclk_in,
    input  wire logic                      rst_n_in,
    // avalon-mm slave
    input  wire kpi_pkg::kpi_bus_req_t     bus_req_in,
    output      kpi_pkg::kpi_bus_rsp_t     bus_rsp_out,
    // keypad pins
    input  wire logic [PINS-1:0]           key_pin_in,
    // cpu interrupt and stop wakeup
    output      logic                      key_irq_out,
    output      logic                      stop_wakeup_out
);
    import kpi_pkg::*;

    // two-stage synchroniser, then one more stage for edge history
    logic [PINS-1:0] sync1_q, sync1_d;
    logic [PINS-1:0] sync2_q, sync2_d;
    logic [PINS-1:0] prev_q, prev_d;

    always_comb begin
        sync1_d = key_pin_in;
        sync2_d = sync1_q;
        prev_d  = sync2_q;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            sync1_q <= '1;
            sync2_q <= '1;
            prev_q  <= '1;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // control state
    logic [3:0]      polarity_q, polarity_d;
    logic            key_irq_enable_q, key_irq_enable_d;
    logic            detect_mode_q, detect_mode_d;
    logic [PINS-1:0] key_pin_enable_q, key_pin_enable_d;
    logic            stop_mode_q, stop_mode_d;
    logic            key_event_flag_q, key_event_flag_d;
    logic            key_irq_q, key_irq_d;
    logic            wakeup_q, wakeup_d;

    // bus state
    kpi_bus_state_t  bus_state_q, bus_state_d;
    logic [31:0]     rdata_q, rdata_d;
    logic            waitreq_q, waitreq_d;
    logic            rd_stsctl_q, rd_stsctl_d;

    // per-pin sense: inverted pins are active-high
    logic [PINS-1:0] invert;
    logic [PINS-1:0] now_asserted;
    logic [PINS-1:0] was_asserted;
    logic            edge_seen;
    logic            level_seen;

    always_comb begin
        invert = '0;
        // (RL1) upper pins polarity select
        invert[PINS-1:KPI_POL_LSB] = polarity_q;
        // (RL8) lower pins stay falling/low
        invert[KPI_POL_LSB-1:0] = '0;
        // (RL9) disabled pins are masked out
        now_asserted   = (sync2_q ^ ~invert) & key_pin_enable_q;
        was_asserted   = (prev_q  ^ ~invert) & key_pin_enable_q;
        // (RL11) deasserted sample then asserted sample
        // (RL12) only when every enabled pin was deasserted
        edge_seen  = (|(now_asserted & ~was_asserted)) && (was_asserted == '0);
        // (RL7) level term only in edge-and-level mode
        level_seen = detect_mode_q && (|now_asserted);
    end

    // bus decode
    logic is_wr;
    logic is_rd;
    logic ack_write;

    always_comb begin
        is_wr     = bus_req_in.write && (bus_state_q == KPI_BUS_IDLE);
        is_rd     = bus_req_in.read && !bus_req_in.write && (bus_state_q == KPI_BUS_IDLE);
        ack_write = is_wr && (bus_req_in.address == KPI_OFF_STSCTL)
                    && bus_req_in.writedata[KPI_ACK_BIT];
    end

    always_comb begin
        polarity_d       = polarity_q;
        key_irq_enable_d = key_irq_enable_q;
        detect_mode_d    = detect_mode_q;
        key_pin_enable_d = key_pin_enable_q;
        stop_mode_d      = stop_mode_q;
        bus_state_d      = KPI_BUS_IDLE;
        rdata_d          = rdata_q;
        waitreq_d        = 1'b1;
        rd_stsctl_d      = 1'b0;
        if (is_wr || is_rd) begin
            bus_state_d = KPI_BUS_DONE;
            waitreq_d   = 1'b0;
        end
        if (is_wr) begin
            if (bus_req_in.address == KPI_OFF_STSCTL) begin
                polarity_d       = bus_req_in.writedata[KPI_POL_LSB +: 4];
                key_irq_enable_d = bus_req_in.writedata[KPI_IE_BIT];
                detect_mode_d    = bus_req_in.writedata[KPI_MODE_BIT];
            end else if (bus_req_in.address == KPI_OFF_PINEN) begin
                key_pin_enable_d = bus_req_in.writedata[PINS-1:0];
            end else if (bus_req_in.address == KPI_OFF_STOP) begin
                stop_mode_d = bus_req_in.writedata[0];
            end
        end
        if (is_rd) begin
            if (bus_req_in.address == KPI_OFF_STSCTL) begin
                rd_stsctl_d = 1'b1;
                // (RL5) ack position reads zero
                rdata_d = {24'h00_0000, polarity_q, key_event_flag_q, 1'b0,
                           key_irq_enable_q, detect_mode_q};
            end else if (bus_req_in.address == KPI_OFF_PINEN) begin
                rdata_d = {{(32-PINS){1'b0}}, key_pin_enable_q};
            end else if (bus_req_in.address == KPI_OFF_STOP) begin
                rdata_d = {31'h0000_0000, stop_mode_q};
            end else begin
                rdata_d = KPI_UNMAPPED;
            end
        end
    end

    always_comb begin
        key_event_flag_d = key_event_flag_q;
        // (RL3) write-one acknowledge clears
        if (ack_write) begin
            key_event_flag_d = 1'b0;
        end
        // (RL2) set wins over clear
        // (RL4) level keeps re-setting
        if (!stop_mode_q && (edge_seen || level_seen)) begin
            key_event_flag_d = 1'b1;
        end
        // (RL15) level irq from flag and enable
        // (RL6) enable gates cpu request
        key_irq_d = key_event_flag_d && key_irq_enable_d;
        // (RL13) stop mode: level only, no edge history
        // pins still pass the synchroniser; raw pins would risk metastability
        wakeup_d  = stop_mode_q && (|now_asserted);
    end

    always_ff @(posedge mclk_in) begin
        // (RL14) reset clears controls and flag
        if (!rst_n_in) begin
            polarity_q       <= KPI_POL_RST;
            key_irq_enable_q <= 1'b0;
            detect_mode_q    <= 1'b0;
            key_pin_enable_q <= KPI_PINEN_RST;
            stop_mode_q      <= 1'b0;
            key_event_flag_q <= 1'b0;
            key_irq_q        <= 1'b0;
            wakeup_q         <= 1'b0;
            bus_state_q      <= KPI_BUS_IDLE;
            rdata_q          <= KPI_UNMAPPED;
            waitreq_q        <= 1'b1;
            rd_stsctl_q      <= 1'b0;
        end else begin
            polarity_q       <= polarity_d;
            key_irq_enable_q <= key_irq_enable_d;
            detect_mode_q    <= detect_mode_d;
            key_pin_enable_q <= key_pin_enable_d;
            stop_mode_q      <= stop_mode_d;
            key_event_flag_q <= key_event_flag_d;
            key_irq_q        <= key_irq_d;
            wakeup_q         <= wakeup_d;
            bus_state_q      <= bus_state_d;
            rdata_q          <= rdata_d;
            waitreq_q        <= waitreq_d;
            rd_stsctl_q      <= rd_stsctl_d;
        end
    end

    // waitrequest from its own flop: low only in the answer cycle, two edges per access
    always_comb begin
        bus_rsp_out.waitrequest   = waitreq_q;
        bus_rsp_out.readdatavalid = 1'b0;
        bus_rsp_out.readdata      = rdata_q;
    end
    assign key_irq_out     = key_irq_q;
    assign stop_wakeup_out = wakeup_q;

    // checks
    property p_irq_follows;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |-> (key_irq_q == (key_event_flag_q && key_irq_enable_q));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not flag and enable"); // RL15

    property p_irq_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !key_irq_enable_q |-> !key_irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with enable low"); // RL6

    property p_ack_clears;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ack_write && !edge_seen && !level_seen) |=> !key_event_flag_q;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear flag"); // RL3

    property p_edge_sets;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (edge_seen && !stop_mode_q) |=> key_event_flag_q;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge lost"); // RL2

    property p_level_holds;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (detect_mode_q && (|now_asserted) && !stop_mode_q) |=> key_event_flag_q;
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level did not hold flag"); // RL4

    property p_ack_reads_zero;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!waitreq_q && rd_stsctl_q) |-> !bus_rsp_out.readdata[KPI_ACK_BIT];
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack read nonzero"); // RL5

    property p_disabled_quiet;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (key_pin_enable_q == '0) |-> !edge_seen && !level_seen;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled pin fired"); // RL9

    property p_edge_only_no_level;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!detect_mode_q && !edge_seen && !key_event_flag_q) |=> !key_event_flag_q;
    endproperty
    a_edge_only_no_level: assert property (p_edge_only_no_level) // RL7
        else $error("flag set without edge");

    property p_edge_blocked;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!detect_mode_q && !key_event_flag_q && (was_asserted != '0)) |=> !key_event_flag_q;
    endproperty
    a_edge_blocked: assert property (p_edge_blocked) else $error("edge from busy pins"); // RL12

    // level re-set must beat a same-cycle acknowledge
    property p_level_beats_ack;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ack_write && level_seen && !stop_mode_q) |=> key_event_flag_q;
    endproperty
    a_level_beats_ack: assert property (p_level_beats_ack) else $error("ack beat level"); // RL4

    property p_flag_cause;
        @(posedge mclk_in) disable iff (!rst_n_in)
        $rose(key_event_flag_q) |-> ($past(edge_seen) || $past(level_seen));
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag rose without event"); // RL2

    property p_stop_no_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (stop_mode_q && !key_event_flag_q) |=> !key_event_flag_q;
    endproperty
    a_stop_no_set: assert property (p_stop_no_set) else $error("flag set in stop"); // RL13

    property p_stop_wakes;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (stop_mode_q && (|now_asserted)) |=> stop_wakeup_out;
    endproperty
    a_stop_wakes: assert property (p_stop_wakes) else $error("no wakeup in stop"); // RL13

    // rising sense on the lowest upper pin: low sample, then high sample
    sequence s_rise_low;
        key_pin_enable_q[KPI_POL_LSB] && polarity_q[0] && !sync2_q[KPI_POL_LSB];
    endsequence

    sequence s_rise_high;
        key_pin_enable_q[KPI_POL_LSB] && polarity_q[0] && sync2_q[KPI_POL_LSB]
        && (was_asserted == '0) && !stop_mode_q;
    endsequence

    property p_rise_sets;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_rise_low ##1 s_rise_high |=> key_event_flag_q;
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge lost"); // RL1 RL11

    // bus answer: one low waitrequest cycle, then stall again
    sequence s_bus_taken;
        is_wr || is_rd;
    endsequence

    sequence s_bus_answer;
        !bus_rsp_out.waitrequest ##1 bus_rsp_out.waitrequest;
    endsequence

    property p_one_wait;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_bus_taken |=> s_bus_answer;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer not one cycle");
endmodule // kpi_keypad_interrupt_unit

// ===== verif/kpi_key_model.sv
// keypad switch model: drives pin levels toward the unit
`timescale 1ns/1ns
module kpi_key_model (
    // clock
    input  wire logic       mclk_in,
    // requested switch levels
    input  wire logic [7:0] key_set_in,
    // pins toward the unit
    output      logic [7:0] key_pin_out
);
    // switches idle high as behind a pull-up; they only move after an edge
    initial key_pin_out = 8'hff;
    always @(posedge mclk_in) begin
        key_pin_out <= key_set_in;
    end
endmodule // kpi_key_model

// ===== verif/tb_top.sv
// testbench: register, detection and wakeup scenarios for the keypad unit
`timescale 1ns/1ns
module tb_top;
    import kpi_pkg::*;
    logic         mclk_in   = 1'b0;
    logic         rst_n_in  = 1'b0;
    kpi_bus_req_t req       = '0;
    kpi_bus_rsp_t rsp;
    logic [7:0]   key_set   = 8'hff;
    logic [7:0]   key_pin;
    logic         irq;
    logic         wake;
    logic [31:0]  rd;
    int           error_cnt = 0;
    int           checked   = 0;

    always #2 mclk_in = ~mclk_in;

    kpi_keypad_interrupt_unit i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_req_in(req),
        .bus_rsp_out(rsp), .key_pin_in(key_pin), .key_irq_out(irq), .stop_wakeup_out(wake));
    kpi_key_model i_keys (.mclk_in(mclk_in), .key_set_in(key_set), .key_pin_out(key_pin));

    task automatic report_and_stop();
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    // one avalon transfer; held until waitrequest is seen low, a hang ends in the watchdog
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        req <= {~wr, wr, a, d};
        do begin
            @(posedge mclk_in);
        end while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req <= '0;
    endtask

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h0000_0000);
        cmp_val(name, exp, rd);
    endtask

    // pin change needs model, two sync stages and the flag stage to land
    task automatic press(input logic [7:0] v);
        @(posedge mclk_in);
        key_set <= v;
        repeat (8) @(posedge mclk_in);
    endtask

    task automatic t_reset();
        rd_chk("stsctl", KPI_OFF_STSCTL, 32'h0000_0000);
        rd_chk("pinen", KPI_OFF_PINEN, {24'h00_0000, KPI_PINEN_RST});
        rd_chk("unmapped", 4'hc, KPI_UNMAPPED);
        cmp_val("irq", {31'h0, irq}, 32'h0000_0000);
        cmp_val("readdatavalid", 32'h0000_0000, {31'h0, rsp.readdatavalid});
    endtask

    task automatic t_edge();
        bus_xfer(1'b1, KPI_OFF_PINEN, 32'h0000_0003);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0000);
        press(8'hfb);
        rd_chk("disabled pin", KPI_OFF_STSCTL, 32'h0000_0000);
        press(8'hfa);
        rd_chk("fall pin0", KPI_OFF_STSCTL, 32'h0000_0008);
        cmp_val("irq masked", {31'h0, irq}, 32'h0000_0000);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0000);
        rd_chk("ack zero", KPI_OFF_STSCTL, 32'h0000_0008);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0004);
        rd_chk("ack one", KPI_OFF_STSCTL, 32'h0000_0000);
        press(8'hf8);
        rd_chk("not from idle", KPI_OFF_STSCTL, 32'h0000_0000);
        press(8'hff);
    endtask

    task automatic t_polarity();
        press(8'hef);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0010);
        bus_xfer(1'b1, KPI_OFF_PINEN, 32'h0000_0010);
        press(8'hff);
        rd_chk("rise pin4", KPI_OFF_STSCTL, 32'h0000_0018);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0014);
        press(8'hef);
        rd_chk("fall pin4", KPI_OFF_STSCTL, 32'h0000_0010);
        press(8'hff);
    endtask

    task automatic t_level();
        bus_xfer(1'b1, KPI_OFF_PINEN, 32'h0000_0001);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0007);
        press(8'hfe);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0007);
        rd_chk("level hold", KPI_OFF_STSCTL, 32'h0000_000b);
        cmp_val("irq on", {31'h0, irq}, 32'h0000_0001);
        press(8'hff);
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0007);
        rd_chk("level off", KPI_OFF_STSCTL, 32'h0000_0003);
        cmp_val("irq off", {31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic t_stop();
        // flag already cleared above before stop is entered
        bus_xfer(1'b1, KPI_OFF_STOP, 32'h0000_0001);
        rd_chk("stop reg", KPI_OFF_STOP, 32'h0000_0001);
        press(8'hfe);
        cmp_val("wakeup", {31'h0, wake}, 32'h0000_0001);
        rd_chk("stop no flag", KPI_OFF_STSCTL, 32'h0000_0003);
        press(8'hff);
        cmp_val("wakeup off", {31'h0, wake}, 32'h0000_0000);
        bus_xfer(1'b1, KPI_OFF_STOP, 32'h0000_0000);
    endtask

    // mid-run reset with a live flag and irq
    task automatic t_reset_mid();
        bus_xfer(1'b1, KPI_OFF_STSCTL, 32'h0000_0003);
        press(8'hfe);
        cmp_val("irq before reset", {31'h0, irq}, 32'h0000_0001);
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        cmp_val("irq after reset", {31'h0, irq}, 32'h0000_0000);
        cmp_val("wakeup after reset", {31'h0, wake}, 32'h0000_0000);
        rd_chk("stsctl after reset", KPI_OFF_STSCTL, 32'h0000_0000);
        rd_chk("pinen after reset", KPI_OFF_PINEN, {24'h00_0000, KPI_PINEN_RST});
        rd_chk("stop after reset", KPI_OFF_STOP, 32'h0000_0000);
        press(8'hff);
    endtask

    initial begin
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_edge();
        t_polarity();
        t_level();
        t_stop();
        t_reset_mid();
        report_and_stop();
    end

    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #40000;
        error_cnt++;
        report_and_stop();
    end
endmodule // tb_top
